// >>> mmc_ctrl.sv
// Modem mode and status controller: command/online mode, result codes,
// outgoing buffering and forwarding, incoming header strip, DCD/DSR,
// auto registration, AXI4-Lite registers and one interrupt.
// Assumes a byte-wide host serial stream and a packet-level network side.
//
// Functional notes
// - Auto-answer: incoming call or datagram puts device online, data flows unprompted.
// - Auto-answer on when register holds 1; else host answers after RING.
// - Successful dial reports CONNECT or 1, then device goes online.
// - Online: commands ignored, autobaud suppressed, flow control enabled if configured.
// - SLIP start or dialing enters online; online only moves data, no responses.
// - Outgoing data buffered until forwarding condition, then sent behind a header.
// - Incoming packets lose their header; payload delivered subject to flow control.
// - Escape sequence or dropped DTR (when enabled) returns to command mode.
// - Valid escape answered with OK or 0; host assumes power loss otherwise.
// - DCD follows connection (default), RF in range or registration.
// - DSR follows connection, RF or registration; by default always asserted.
// - Auto registration with zero timeout registers at power-up and on loss.
// - Network status is readable only in command mode; the code reads zero only online, so it is also readable while dialing.
// - Network status: RF bit 7, registered bit 0, connected bit 2 without bit 3.
// - DTR escape options need DTR low at least 15 ms; default ignores DTR.
`timescale 1ns/1ns
`include "mmc_cfg.svh"
module mmc_ctrl import mmc_pkg::*; #(
  parameter int DTR_LOW_CYC = `MMC_DTR_LOW_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  mmc_byte_t        host_rx,
  output logic             host_rx_ready,
  output mmc_byte_t        host_tx,
  input  wire logic        host_tx_ready,
  input  wire logic        host_cts,
  input  wire logic        dtr,
  output logic             dcd,
  output logic             dsr,
  output logic             autobaud_en,
  output logic             flow_en,
  input  mmc_link_t        link,
  input  wire logic        net_call,
  output logic             dial_req,
  input  wire logic        dial_ok,
  input  wire logic        dial_fail,
  output logic             reg_req,
  output logic             hangup,
  output mmc_byte_t        net_tx,
  output logic             net_tx_last,
  input  wire logic        net_tx_ready,
  input  mmc_byte_t        net_rx,
  input  wire logic        net_rx_last,
  output logic             net_rx_ready,
  output logic             irq
);
  mmc_state_t state_q, state_d;
  mmc_fwd_t   fw_q;
  mmc_rsp_t   rsp_code;
  logic [31:0] ctrl_q, ip_q, rd_d;
  logic [15:0] port_q;
  logic [7:0]  tmo_q, lvl_q, cnt_q, ptr_q, ptr_d, mem_rd, cmd_ch_q;
  logic [7:0]  aw_q, ns;
  logic [31:0] wd_q;
  logic [3:0]  ws_q, hdr_q;
  logic [`MMC_IRQ_W-1:0] sts_q, mask_q, ev;
  logic [20:0] dtr_cnt_q;
  logic [1:0]  plus_q, pos_q;
  logic aw_h_q, w_h_q, bad_q, ring_q, pu_q, reg_prev_q, slip_q, fnow_q, dtr_done_q;
  logic wr_go, rd_go, rsp_start, rsp_busy, rsp_ready;
  logic rx_take, rx_cr, esc_plus, dtr_esc, go_online, go_cmd, auto_ans, fwd_start;
  logic pay_take, hdr_take, in_take;
  mmc_byte_t rsp_tx;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  function automatic logic pick(input logic [1:0] sel, input mmc_link_t l, input logic dflt);
    case (sel)
      2'b00:   return dflt;
      2'b01:   return l.connected;
      2'b10:   return l.rf_in_range;
      default: return l.registered;
    endcase
  endfunction

  // Register bus: address and data may arrive in either order
  wire wr_ok   = aw_h_q && w_h_q && !bvalid;
  wire [7:0] wa = aw_q;
  wire [31:0] wv = wd_q;
  wire w_ctrl  = wr_ok && wa == `MMC_OFS_CTRL;
  wire w_tmo   = wr_ok && wa == `MMC_OFS_REG_TMO;
  wire w_sts   = wr_ok && wa == `MMC_OFS_IRQ_STS;
  wire w_mask  = wr_ok && wa == `MMC_OFS_IRQ_MASK;
  wire w_ip    = wr_ok && wa == `MMC_OFS_DEST_IP;
  wire w_port  = wr_ok && wa == `MMC_OFS_DEST_PORT;
  wire w_lvl   = wr_ok && wa == `MMC_OFS_FWD_LVL;
  wire w_cmd   = wr_ok && wa == `MMC_OFS_CMD;
  wire w_map   = w_ctrl | w_tmo | w_sts | w_mask | w_ip | w_port | w_lvl | w_cmd;
  assign awready = !aw_h_q;
  assign wready  = !w_h_q;
  assign arready = !rvalid;
  assign rd_go   = arvalid && arready;

  wire auto_on   = ctrl_q[0];
  wire verbose   = ctrl_q[1];
  wire flow_cfg  = ctrl_q[2];
  wire [1:0] dcd_sel = ctrl_q[4:3];
  wire [1:0] dsr_sel = ctrl_q[6:5];
  wire [1:0] dtr_mode = ctrl_q[8:7];
  wire auto_reg  = ctrl_q[9];
  wire srv_on    = ctrl_q[10] | ctrl_q[11];
  wire online    = state_q == ST_ONLINE;

  assign ns = {link.rf_in_range, 1'b0, auto_reg, 1'b0, !link.connected, link.connected, 1'b0,
               link.registered};
  always_comb begin
    rd_d = 32'h0000_0000;
    case (araddr)
      `MMC_OFS_CTRL:      rd_d = ctrl_q;
      `MMC_OFS_REG_TMO:   rd_d = {24'h0, tmo_q};
      `MMC_OFS_NET_STAT:  rd_d = online ? 32'h0000_0000 : {24'h0, ns};
      `MMC_OFS_MODE:      rd_d = {16'h0, cnt_q, 4'h0, fw_q, state_q};
      `MMC_OFS_IRQ_STS:   rd_d = {27'h0, sts_q};
      `MMC_OFS_IRQ_MASK:  rd_d = {27'h0, mask_q};
      `MMC_OFS_DEST_IP:   rd_d = ip_q;
      `MMC_OFS_DEST_PORT: rd_d = {16'h0, port_q};
      `MMC_OFS_FWD_LVL:   rd_d = {24'h0, lvl_q};
      default:            rd_d = 32'h0000_0000;
    endcase
  end
  wire rd_map = araddr <= `MMC_OFS_FWD_LVL && araddr[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_q <= 1'b0; w_h_q <= 1'b0; bvalid <= 1'b0; rvalid <= 1'b0;
      aw_q <= 8'h00; wd_q <= 32'h0000_0000; ws_q <= 4'h0;
      bresp <= 2'b00; rresp <= 2'b00; rdata <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin aw_h_q <= 1'b1; aw_q <= awaddr; end
      if (wvalid && wready) begin w_h_q <= 1'b1; wd_q <= wdata; ws_q <= wstrb; end
      if (wr_ok) begin
        aw_h_q <= 1'b0; w_h_q <= 1'b0; bvalid <= 1'b1;
        bresp <= w_map ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (rd_go) begin
        rvalid <= 1'b1; rdata <= rd_d; rresp <= rd_map ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Host input: command line parsing in command mode, buffering online
  wire buf_full  = cnt_q == 8'hFF;
  assign host_rx_ready = online ? (fw_q == FW_IDLE && !buf_full) : (state_q == ST_CMD && !rsp_busy);
  assign rx_take  = host_rx.valid && host_rx_ready;
  assign rx_cr    = rx_take && !online && host_rx.data == `MMC_CH_CR;
  assign esc_plus = rx_take && online && host_rx.data == `MMC_CH_PLUS && plus_q == 2'b10;
  assign dtr_esc  = online && !dtr_done_q && dtr_mode != 2'b00 && dtr_cnt_q == 21'(DTR_LOW_CYC);
  assign auto_ans = state_q == ST_CMD && net_call && auto_on && srv_on;
  wire line_bad   = bad_q || pos_q != 2'b11;
  wire ata        = rx_cr && !line_bad && cmd_ch_q == `MMC_CH_A;
  wire atd        = rx_cr && !line_bad && cmd_ch_q == `MMC_CH_D;
  wire ato        = rx_cr && !line_bad && cmd_ch_q == `MMC_CH_O && link.connected;
  wire empty_line = rx_cr && pos_q == 2'b00 && !bad_q;
  assign dial_req = atd;

  always_comb begin
    state_d   = state_q;
    rsp_start = 1'b0;
    rsp_code  = RSP_OK;
    case (state_q)
      ST_CMD: begin
        if (slip_q || auto_ans) begin
          state_d = ST_ONLINE;
        end else if (atd) begin
          state_d = ST_DIAL;
        end else if ((ata && ring_q) || ato) begin
          state_d = ST_ONLINE; rsp_start = 1'b1; rsp_code = RSP_CONNECT;
        end else if (rx_cr && !empty_line) begin
          rsp_start = 1'b1;
          rsp_code  = (line_bad || ata || cmd_ch_q == `MMC_CH_O) ? RSP_ERROR : RSP_OK;
        end else if (net_call && srv_on && !ring_q && !rsp_busy) begin
          rsp_start = 1'b1; rsp_code = RSP_RING;
        end
      end
      ST_DIAL: begin
        if (dial_ok) begin
          state_d = ST_ONLINE; rsp_start = 1'b1; rsp_code = RSP_CONNECT;
        end else if (dial_fail) begin
          state_d = ST_CMD; rsp_start = 1'b1; rsp_code = RSP_ERROR;
        end
      end
      ST_ONLINE: begin
        if (esc_plus || dtr_esc) begin
          state_d = ST_CMD; rsp_start = 1'b1; rsp_code = RSP_OK;
        end
      end
      default: state_d = ST_CMD;
    endcase
  end
  assign go_online = state_d == ST_ONLINE && !online;
  assign go_cmd    = state_d == ST_CMD && online;
  assign autobaud_en = !online;
  assign flow_en     = online && flow_cfg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_CMD; pos_q <= 2'b00; bad_q <= 1'b0; cmd_ch_q <= 8'h00;
      plus_q <= 2'b00; ring_q <= 1'b0; slip_q <= 1'b0; fnow_q <= 1'b0;
      dtr_cnt_q <= 21'h0; dtr_done_q <= 1'b0; hangup <= 1'b0;
    end else begin
      state_q <= state_d;
      hangup  <= dtr_esc && dtr_mode == 2'b10;
      if (rx_cr) begin
        pos_q <= 2'b00; bad_q <= 1'b0;
      end else if (rx_take && !online) begin
        if (pos_q == 2'b00 && host_rx.data != `MMC_CH_A) bad_q <= 1'b1;
        if (pos_q == 2'b01 && host_rx.data != `MMC_CH_T) bad_q <= 1'b1;
        if (pos_q == 2'b10) cmd_ch_q <= host_rx.data;
        // A fourth character before CR makes the line too long
        if (pos_q == 2'b11) bad_q <= 1'b1;
        else pos_q <= pos_q + 2'b01;
      end
      if (!online) plus_q <= 2'b00;
      else if (rx_take) plus_q <= (host_rx.data == `MMC_CH_PLUS) ? plus_q + 2'b01 : 2'b00;
      if (net_call && srv_on && state_q == ST_CMD) ring_q <= 1'b1;
      else if (go_online || !link.connected) ring_q <= 1'b0;
      if (wr_ok && wa == `MMC_OFS_CMD && ws_q[0] && wv[0]) slip_q <= 1'b1;
      else if (state_q == ST_CMD) slip_q <= 1'b0;
      if (wr_ok && wa == `MMC_OFS_CMD && ws_q[0] && wv[1]) fnow_q <= 1'b1;
      else if (fwd_start || !online) fnow_q <= 1'b0;
      if (dtr) begin
        dtr_cnt_q <= 21'h0; dtr_done_q <= 1'b0;
      end else begin
        if (dtr_cnt_q != 21'(DTR_LOW_CYC)) dtr_cnt_q <= dtr_cnt_q + 21'h1;
        if (dtr_esc) dtr_done_q <= 1'b1;
      end
    end
  end

  // Outgoing path: writes are held off while a packet drains, trading
  // host throughput for a buffer with no wrap-around hazard
  wire hdr_last = hdr_q == `MMC_HDR_LEN - 4'h1;
  assign fwd_start = online && fw_q == FW_IDLE && cnt_q != 8'h00 &&
                     (cnt_q >= lvl_q || fnow_q || buf_full);
  assign hdr_take  = fw_q == FW_HDR && net_tx_ready;
  assign pay_take  = fw_q == FW_PAY && net_tx_ready;
  assign ptr_d = fwd_start ? 8'h00 : (pay_take ? ptr_q + 8'h01 : ptr_q);
  assign net_tx.valid = fw_q != FW_IDLE;
  assign net_tx.data  = fw_q == FW_PAY ? mem_rd :
                        (hdr_q < 4'h4 ? ip_q[8 * (3 - hdr_q) +: 8] : port_q[8 * (5 - hdr_q) +: 8]);
  assign net_tx_last  = fw_q == FW_PAY && ptr_q == cnt_q - 8'h01;

  mmc_mem u_mem (
    .aclk    (aclk),
    .wr_en   (rx_take && online),
    .wr_addr (cnt_q),
    .wr_data (host_rx.data),
    .rd_addr (ptr_d),
    .rd_data (mem_rd)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fw_q <= FW_IDLE; cnt_q <= 8'h00; ptr_q <= 8'h00; hdr_q <= 4'h0;
    end else begin
      ptr_q <= ptr_d;
      case (fw_q)
        FW_IDLE: begin
          if (fwd_start) begin fw_q <= FW_HDR; hdr_q <= 4'h0; end
          else if (rx_take && online) cnt_q <= cnt_q + 8'h01;
        end
        FW_HDR: if (hdr_take) begin
          hdr_q <= hdr_q + 4'h1;
          if (hdr_last) fw_q <= FW_PAY;
        end
        FW_PAY: if (pay_take && net_tx_last) begin fw_q <= FW_IDLE; cnt_q <= 8'h00; end
        default: fw_q <= FW_IDLE;
      endcase
    end
  end

  // Incoming path: header bytes are dropped, payload waits on the host
  logic [3:0] in_hdr_q;
  wire in_hdr  = in_hdr_q != `MMC_HDR_LEN;
  wire pay_ok  = host_tx_ready && (!flow_en || host_cts) && !rsp_busy;
  assign net_rx_ready = online && (in_hdr || pay_ok);
  assign in_take = net_rx.valid && net_rx_ready;
  assign rsp_ready = host_tx_ready;
  assign host_tx.valid = rsp_busy ? rsp_tx.valid : (online && !in_hdr && net_rx.valid && pay_ok);
  assign host_tx.data  = rsp_busy ? rsp_tx.data : net_rx.data;

  always_ff @(posedge aclk) begin
    if (!aresetn) in_hdr_q <= 4'h0;
    else if (in_take && net_rx_last) in_hdr_q <= 4'h0;
    else if (in_take && in_hdr) in_hdr_q <= in_hdr_q + 4'h1;
  end

  mmc_resp u_resp (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (rsp_start && !rsp_busy),
    .code     (rsp_code),
    .verbose  (verbose),
    .tx_ready (rsp_ready),
    .tx       (rsp_tx),
    .busy     (rsp_busy)
  );

  // Status lines, registration and interrupt
  wire reg_lost = reg_prev_q && !link.registered;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcd <= 1'b0; dsr <= 1'b0; reg_req <= 1'b0; pu_q <= 1'b1; reg_prev_q <= 1'b0;
      ctrl_q <= `MMC_CTRL_RST; tmo_q <= `MMC_REG_TMO_RST; lvl_q <= `MMC_FWD_LVL_RST;
      ip_q <= 32'h0000_0000; port_q <= 16'h0000; sts_q <= '0; mask_q <= '0;
    end else begin
      dcd <= pick(dcd_sel + 2'b01, link, 1'b1);
      dsr <= pick(dsr_sel, link, 1'b1);
      reg_prev_q <= link.registered;
      reg_req <= auto_reg && ((pu_q && !link.registered) || (reg_lost && tmo_q == 8'h00));
      if (auto_reg) pu_q <= 1'b0;
      if (w_ctrl) ctrl_q <= merge(ctrl_q, wv, ws_q);
      if (w_tmo && ws_q[0]) tmo_q <= wv[7:0];
      if (w_lvl && ws_q[0]) lvl_q <= wv[7:0];
      if (w_ip) ip_q <= merge(ip_q, wv, ws_q);
      if (w_port) port_q <= 16'(merge({16'h0, port_q}, wv, ws_q));
      if (w_mask && ws_q[0]) mask_q <= wv[`MMC_IRQ_W-1:0];
      sts_q <= (sts_q & ~((w_sts && ws_q[0]) ? wv[`MMC_IRQ_W-1:0] : '0)) | ev;
    end
  end
  assign ev = {pay_take && net_tx_last, reg_lost, go_cmd, go_online,
               rsp_start && !rsp_busy && rsp_code == RSP_RING};
  assign irq = |(sts_q & mask_q);

  dial_connect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_DIAL && dial_ok && !rsp_busy |-> rsp_code == RSP_CONNECT ##1 state_q == ST_ONLINE)
    else $error("dial success did not report connect and go online");
  auto_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_ans |=> online ##1 net_rx_ready == (in_hdr || pay_ok))
    else $error("auto answer did not go online");
  online_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    online |-> !dial_req && !autobaud_en && flow_en == flow_cfg)
    else $error("online mode still acts on commands");
  escape_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
    esc_plus && !rsp_busy |-> rsp_start && rsp_code == RSP_OK ##1 state_q == ST_CMD && rsp_busy)
    else $error("escape not answered with ok");
  bad_prefix_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_cr && bad_q && !online |-> rsp_code == RSP_ERROR && state_d == ST_CMD)
    else $error("line without prefix not refused");
  dcd_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && $stable(dcd_sel) && dcd_sel == 2'b00 |=> dcd == $past(link.connected))
    else $error("dcd does not follow connection");
  dsr_default_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dsr_sel == 2'b00 && aresetn |=> dsr)
    else $error("dsr not held asserted by default");
  netstat_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && online && araddr == `MMC_OFS_NET_STAT |=> rvalid && rdata == 32'h0000_0000)
    else $error("network status visible online");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev != '0 && mask_q == ev |=> irq)
    else $error("unmasked event gave no interrupt");
endmodule

// >>> mmc_cfg.svh
// Constants of the modem mode and status controller: offsets, fields,
// reset values, character codes and timing counts.
// Assumes a 125 MHz aclk and byte-wide host and network streams.
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH

`define MMC_CLK_HZ        125000000
`define MMC_DTR_MIN_MS    15
`define MMC_DTR_LOW_CYC   ((`MMC_CLK_HZ / 1000) * `MMC_DTR_MIN_MS)

`define MMC_OFS_CTRL      8'h00
`define MMC_OFS_REG_TMO   8'h04
`define MMC_OFS_NET_STAT  8'h08
`define MMC_OFS_MODE      8'h0C
`define MMC_OFS_IRQ_STS   8'h10
`define MMC_OFS_IRQ_MASK  8'h14
`define MMC_OFS_DEST_IP   8'h18
`define MMC_OFS_DEST_PORT 8'h1C
`define MMC_OFS_FWD_LVL   8'h20
`define MMC_OFS_CMD       8'h24

`define MMC_CTRL_RST      32'h0000_0002
`define MMC_REG_TMO_RST   8'h3C
`define MMC_FWD_LVL_RST   8'h40

`define MMC_NS_RF         7
`define MMC_NS_AUTOREG    5
`define MMC_NS_CONN       2
`define MMC_NS_NOTCONN    3
`define MMC_NS_REG        0

`define MMC_IRQ_RING      0
`define MMC_IRQ_ONLINE    1
`define MMC_IRQ_CMD       2
`define MMC_IRQ_REGLOST   3
`define MMC_IRQ_SENT      4
`define MMC_IRQ_W         5

`define MMC_HDR_LEN       4'h6
`define MMC_CH_A          8'h41
`define MMC_CH_T          8'h54
`define MMC_CH_D          8'h44
`define MMC_CH_O          8'h4F
`define MMC_CH_PLUS       8'h2B
`define MMC_CH_CR         8'h0D
`define MMC_CH_LF         8'h0A
`define MMC_CH_ZERO       8'h30

`endif

// >>> mmc_pkg.sv
// Types shared by the modem mode and status controller.
// Assumes nothing beyond a SystemVerilog package scope.
package mmc_pkg;
  typedef enum logic [1:0] {ST_CMD = 2'b00, ST_DIAL = 2'b01, ST_ONLINE = 2'b10} mmc_state_t;
  typedef enum logic [2:0] {RSP_OK = 3'b000, RSP_CONNECT = 3'b001, RSP_RING = 3'b010,
                            RSP_ERROR = 3'b100} mmc_rsp_t;
  typedef enum logic [1:0] {FW_IDLE = 2'b00, FW_HDR = 2'b01, FW_PAY = 2'b10} mmc_fwd_t;
  typedef struct packed {
    logic rf_in_range;
    logic registered;
    logic connected;
  } mmc_link_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mmc_byte_t;
endpackage

// >>> mmc_mem.sv
// Outgoing data buffer: 256 bytes, one write port, registered read.
// Assumes the caller presents the read address one cycle ahead.
`timescale 1ns/1ns
module mmc_mem (
  input  wire logic       aclk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> mmc_resp.sv
// Result message sender: spells a result code as text or as a digit,
// followed by the line end, one byte per accepted beat.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ns
`include "mmc_cfg.svh"
module mmc_resp import mmc_pkg::*; (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      start,
  input  mmc_rsp_t       code,
  input  wire logic      verbose,
  input  wire logic      tx_ready,
  output mmc_byte_t      tx,
  output logic           busy
);
  mmc_rsp_t   code_q;
  logic       verb_q;
  logic       act_q;
  logic [3:0] idx_q;
  logic [8:0] cur;

  // Returns {last, character} for position i of the message
  function automatic logic [8:0] rsp_char(input mmc_rsp_t c, input logic v, input logic [3:0] i);
    logic [55:0] txt;
    logic [3:0]  len;
    logic [7:0]  ch;
    txt = 56'h0;
    len = 4'h1;
    case (c)
      RSP_OK:      begin txt = 56'("OK");      len = 4'h2; end
      RSP_CONNECT: begin txt = 56'("CONNECT"); len = 4'h7; end
      RSP_RING:    begin txt = 56'("RING");    len = 4'h4; end
      default:     begin txt = 56'("ERROR");   len = 4'h5; end
    endcase
    if (!v) begin
      txt = {48'h0, `MMC_CH_ZERO + {5'h0, c}};
      len = 4'h1;
    end
    if (i < len) begin
      ch = txt[8 * (len - 4'h1 - i) +: 8];
    end else if (i == len) begin
      ch = `MMC_CH_CR;
    end else begin
      ch = `MMC_CH_LF;
    end
    return {(v ? (i == len + 4'h1) : (i == len)), ch};
  endfunction

  assign cur      = rsp_char(code_q, verb_q, idx_q);
  assign tx.valid = act_q;
  assign tx.data  = cur[7:0];
  assign busy     = act_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q  <= 1'b0;
      idx_q  <= 4'h0;
      code_q <= RSP_OK;
      verb_q <= 1'b0;
    end else if (!act_q && start) begin
      act_q  <= 1'b1;
      idx_q  <= 4'h0;
      code_q <= code;
      verb_q <= verbose;
    end else if (act_q && tx_ready) begin
      act_q <= !cur[8];
      idx_q <= idx_q + 4'h1;
    end
  end
endmodule

// >>> mmc_host_model.sv
// Host side model: takes result bytes, stalling at random.
// Assumes each byte stands until taken.
`timescale 1ns/1ns
module mmc_host_model import mmc_pkg::*; (
  input  wire logic aclk,
  input  mmc_byte_t tx,
  output logic      rdy
);
  logic [7:0] got[$];
  initial rdy = 1'b0;
  always @(posedge aclk) begin
    if (tx.valid && rdy) got.push_back(tx.data);
    rdy <= 1'($urandom_range(0, 1));
  end
endmodule

// >>> tb_modem_mode_and_status_control.sv
// Self-checking bench of the mode and status controller.
// Assumes the design files and the host model compile first.
`timescale 1ns/1ns
`include "mmc_cfg.svh"
module tb_modem_mode_and_status_control import mmc_pkg::*;;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic host_rx_ready, host_tx_ready, host_cts, dtr, dcd, dsr, autobaud_en, flow_en, net_call, dial_req;
  logic dial_ok, dial_fail, reg_req, hangup, net_tx_last, net_tx_ready, net_rx_last, net_rx_ready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  mmc_byte_t host_rx, host_tx, net_tx, net_rx;
  mmc_link_t link;
  int err_total, n_tests, cyc;
  logic [31:0] ip, pt;
  logic [7:0] ntx[$], exp_q[$], b;
  mmc_ctrl #(.DTR_LOW_CYC(20)) dut (.*);
  mmc_host_model hm (.aclk(aclk), .tx(host_tx), .rdy(host_tx_ready));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic sel_exp(int s, mmc_link_t l);
    return s == 0 ? 1'b1 : s == 1 ? l.connected : s == 2 ? l.rf_in_range : l.registered;
  endfunction
  function automatic logic [31:0] stat_exp(mmc_link_t l);
    return {24'h00_0000, l.rf_in_range, 3'b000, ~l.connected, l.connected, 1'b0, l.registered};
  endfunction
  task automatic give_verdict;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      d = rdata;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic send(string s);
    foreach (s[i]) begin
      host_rx <= {1'b1, s[i]};
      do @(posedge aclk); while (!host_rx_ready);
    end
    host_rx <= '0;
  endtask
  task automatic expect_rsp(string s);
    while (hm.got.size() < s.len()) @(posedge aclk);
    foreach (s[i]) chk("response", 32'(s[i]), 32'(hm.got[i]));
    hm.got.delete();
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (net_tx.valid && net_tx_ready) ntx.push_back(net_tx.data);
    net_tx_ready <= 1'($urandom_range(0, 1));
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, net_call, dial_ok, dial_fail, net_rx_last} = '0;
    {awaddr, araddr, wdata, wstrb, host_rx, net_rx, link} = '0;
    {dtr, host_cts} = 2'b11;
    void'($urandom(99));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Every DSR source, DCD from connection, RF and registration (not the always-on setting), terse results, flow control configured
    for (int s = 0; s < 4; s++) begin
      link <= 3'($urandom_range(0, 7));
      wr(`MMC_OFS_CTRL, 32'(s << 5 | (s % 3) << 3 | 4));
      repeat (2) @(posedge aclk);
      chk("dsr", 32'(sel_exp(s, link)), 32'(dsr));
      chk("dcd", 32'(sel_exp(s % 3 + 1, link)), 32'(dcd));
      rd_reg(`MMC_OFS_NET_STAT, rd);
      chk("net_stat", stat_exp(link), rd);
    end
    wr(`MMC_OFS_IRQ_MASK, 32'h0000_0002);
    send("XY\r");
    expect_rsp("4\r");
    send("ATE\r");
    expect_rsp("0\r");
    send("ATD\r");
    repeat (3) @(posedge aclk);
    dial_ok <= 1'b1;
    @(posedge aclk);
    dial_ok <= 1'b0;
    expect_rsp("1\r");
    rd_reg(`MMC_OFS_MODE, rd);
    chk("state", 32'h0000_0002, 32'(rd[1:0]));
    chk("autobaud", 32'h0000_0000, 32'(autobaud_en));
    chk("flow", 32'h0000_0001, 32'(flow_en));
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(`MMC_OFS_IRQ_STS, 32'h0000_0002);
    chk("irq", 32'h0000_0000, 32'(irq));
    rd_reg(`MMC_OFS_NET_STAT, rd);
    chk("net_stat", 32'h0000_0000, rd);
    send("ATZ\r");
    repeat (20) @(posedge aclk);
    chk("quiet", 32'h0000_0000, 32'(hm.got.size()));
    send("+++");
    expect_rsp("0\r");
    rd_reg(`MMC_OFS_MODE, rd);
    chk("state", 32'h0000_0000, 32'(rd[1:0]));
    wr(`MMC_OFS_IRQ_MASK, 32'h0000_0004);
    chk("irq", 32'h0000_0001, 32'(irq));
    // Auto answer as a server, then a packet in, a forced packet out, DTR escape
    ip = $urandom;
    pt = 32'($urandom_range(0, 65535));
    wr(`MMC_OFS_DEST_IP, ip);
    wr(`MMC_OFS_DEST_PORT, pt);
    wr(`MMC_OFS_CTRL, 32'h0000_0485);
    net_call <= 1'b1;
    @(posedge aclk);
    net_call <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      b = 8'($urandom);
      if (i > 5) exp_q.push_back(b);
      net_rx <= {1'b1, b};
      net_rx_last <= i == 9;
      do @(posedge aclk); while (!net_rx_ready);
    end
    net_rx <= '0;
    net_rx_last <= 1'b0;
    @(posedge aclk);
    chk("rx_count", 32'd4, 32'(hm.got.size()));
    foreach (exp_q[i]) chk("rx_payload", 32'(exp_q[i]), 32'(hm.got[i]));
    hm.got.delete();
    wr(`MMC_OFS_CMD, 32'h0000_0002);
    while (ntx.size() < 13) @(posedge aclk);
    exp_q = {ip[31:24], ip[23:16], ip[15:8], ip[7:0], pt[15:8], pt[7:0], `MMC_CH_A, `MMC_CH_T, 8'h5A,
             `MMC_CH_CR, `MMC_CH_PLUS, `MMC_CH_PLUS, `MMC_CH_PLUS};
    foreach (exp_q[i]) chk("net_tx", 32'(exp_q[i]), 32'(ntx[i]));
    dtr <= 1'b0;
    expect_rsp("0\r");
    dtr <= 1'b1;
    rd_reg(`MMC_OFS_MODE, rd);
    chk("state", 32'h0000_0000, 32'(rd[1:0]));
    give_verdict();
  end
endmodule
